// file: hw/buck_voltage_decay_regs.v
// How it works
// (RULE_01) Rail 2 control bits 7:1 hold rail 2 normal voltage code, read/write.
// (RULE_02) Rail 2 control bit 0: 0 slews down actively, 1 lets output decay.
// (RULE_03) Rail 3 decay control at 22h; bit 0 selects slew (0) or decay (1).
// (RULE_04) Rail 3 decay control bits 7:1 are spare storage, read/write, no function.
// (RULE_05) Rail 3 voltage register at 23h; bits 7:1 hold the normal voltage code.
// (RULE_06) Reset contents come from a per-variant factory image, not one constant.
// (RULE_07) Rail 2 control register sits at offset 21h.
// (RULE_08) Rail 3 uses sleep code only when sleep enabled and sleep pin low.
// (RULE_09) Rail 3 voltage bit 0 is read-only zero and ignores writes.
`timescale 1ns/10ps
`include "rail_regs_consts.vh"
module buck_voltage_decay_regs #(
  parameter [7:0] RAIL2_CONTROL_INIT = `RAIL2_CONTROL_DEF,
  parameter [7:0] RAIL3_DECAY_CONTROL_INIT = `RAIL3_DECAY_CONTROL_DEF,
  parameter [7:0] RAIL3_VOLTAGE_CODE_INIT = `RAIL3_VOLTAGE_CODE_DEF,
  parameter [7:0] RAIL3_SLEEP_CONTROL_INIT = `RAIL3_SLEEP_CONTROL_DEF
) (
  // Clock and reset
  input wire REF_CLK,
  input wire RESET_N,
  // Register port from the serial interface
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  // Sleep pin assigned to rail 3, active low
  input wire SLEEP_N,
  // Regulator controls
  output reg [6:0] RAIL2_VOLTAGE_CODE,
  output reg RAIL2_PASSIVE_DECAY_SELECT,
  output reg [6:0] RAIL3_VOLTAGE_TARGET,
  output reg RAIL3_PASSIVE_DECAY_SELECT
);
  // Stored bytes, straight from the byte cells
  wire [7:0] rail2_control_r;
  wire [7:0] rail3_decay_control_r;
  wire [7:0] rail3_voltage_code_r;
  wire [7:0] rail3_sleep_control_r;

  // One write strobe per mapped offset
  wire rail2_control_wr;
  wire rail3_decay_control_wr;
  wire rail3_voltage_code_wr;
  wire rail3_sleep_control_wr;

  // Rail 3 voltage selection
  wire rail3_sleep_active;
  wire [6:0] rail3_normal_code;
  wire [6:0] rail3_sleep_code;
  wire [6:0] rail3_target_nxt;

  // Next values of the registered outputs
  reg [7:0] rdata_nxt;
  reg [7:0] rdata_hold_nxt;
  reg [6:0] rail2_code_nxt;
  reg rail2_decay_nxt;
  reg rail3_decay_nxt;

  // Bits the host may change in each byte
  localparam [7:0] FULL_MASK = 8'hFF;
  // Bit 0 of the rail 3 voltage byte is read-only zero
  localparam [7:0] CODE_ONLY_MASK = 8'hFE;
  // Factory image of the rail 3 voltage byte with its read-only bit cleared
  localparam [7:0] RAIL3_VOLTAGE_IMAGE = RAIL3_VOLTAGE_CODE_INIT & CODE_ONLY_MASK;

  // True when a write strobe addresses the given offset
  function wr_hit;
    input wr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = wr && (addr == ofs);
    end
  endfunction

  // Voltage code field of a rail byte
  function [6:0] code_field;
    input [7:0] value;
    begin
      code_field = value[`CODE_MSB:`CODE_LSB];
    end
  endfunction

  // Down-transition select of a rail byte: 0 slews actively, 1 lets it decay
  function decay_field;
    input [7:0] value;
    begin
      decay_field = value[`DECAY_BIT];
    end
  endfunction

  // Sleep enable of the rail 3 sleep byte
  function sleep_enable_field;
    input [7:0] value;
    begin
      sleep_enable_field = value[`SLEEP_EN_BIT];
    end
  endfunction

  // Read multiplexer; unmapped offsets answer with a fixed byte
  function [7:0] read_select;
    input [7:0] addr;
    input [7:0] rail2_byte;
    input [7:0] rail3_decay_byte;
    input [7:0] rail3_code_byte;
    input [7:0] rail3_sleep_byte;
    begin
      case (addr)
        `RAIL2_CONTROL_OFS: read_select = rail2_byte;
        `RAIL3_DECAY_CONTROL_OFS: read_select = rail3_decay_byte;
        `RAIL3_VOLTAGE_CODE_OFS: read_select = rail3_code_byte;
        `RAIL3_SLEEP_CONTROL_OFS: read_select = rail3_sleep_byte;
        default: read_select = `UNMAPPED_DATA;
      endcase
    end
  endfunction

  // A read in the same cycle as a write still sees the old byte
  // Unmapped offsets raise no strobe, so writes to them vanish
  assign rail2_control_wr = wr_hit(REG_WR, REG_ADDR, `RAIL2_CONTROL_OFS); // RULE_07
  assign rail3_decay_control_wr = wr_hit(REG_WR, REG_ADDR, `RAIL3_DECAY_CONTROL_OFS); // RULE_03
  assign rail3_voltage_code_wr = wr_hit(REG_WR, REG_ADDR, `RAIL3_VOLTAGE_CODE_OFS); // RULE_05
  assign rail3_sleep_control_wr = wr_hit(REG_WR, REG_ADDR, `RAIL3_SLEEP_CONTROL_OFS); // RULE_08

  // Rail 2 control byte: code in 7:1, decay select in bit 0
  rail_byte_reg #(
    .RESET_VALUE(RAIL2_CONTROL_INIT), // RULE_06
    .WRITE_MASK(FULL_MASK)
  ) u_rail2 (
    .clk(REF_CLK),
    .reset_n(RESET_N),
    .wr_en(rail2_control_wr),
    .wr_data(REG_WDATA),
    .q_r(rail2_control_r)
  );

  // Rail 3 decay byte: bits 7:1 are spare storage with no function
  rail_byte_reg #(
    .RESET_VALUE(RAIL3_DECAY_CONTROL_INIT), // RULE_06
    .WRITE_MASK(FULL_MASK) // RULE_04
  ) u_rail3_decay (
    .clk(REF_CLK),
    .reset_n(RESET_N),
    .wr_en(rail3_decay_control_wr),
    .wr_data(REG_WDATA),
    .q_r(rail3_decay_control_r)
  );

  // Rail 3 voltage byte: a full-byte write moves only the code
  rail_byte_reg #(
    .RESET_VALUE(RAIL3_VOLTAGE_IMAGE), // RULE_06
    .WRITE_MASK(CODE_ONLY_MASK) // RULE_09
  ) u_rail3_vid (
    .clk(REF_CLK),
    .reset_n(RESET_N),
    .wr_en(rail3_voltage_code_wr),
    .wr_data(REG_WDATA),
    .q_r(rail3_voltage_code_r)
  );

  // Rail 3 sleep byte: sleep code in 7:1, sleep enable in bit 0
  rail_byte_reg #(
    .RESET_VALUE(RAIL3_SLEEP_CONTROL_INIT), // RULE_06
    .WRITE_MASK(FULL_MASK)
  ) u_rail3_sleep (
    .clk(REF_CLK),
    .reset_n(RESET_N),
    .wr_en(rail3_sleep_control_wr),
    .wr_data(REG_WDATA),
    .q_r(rail3_sleep_control_r)
  );

  // Sleep code only while enabled and the pin is low
  // The pin is taken as synchronous; a raw pin needs a synchroniser upstream
  assign rail3_sleep_active = sleep_enable_field(rail3_sleep_control_r) && !SLEEP_N; // RULE_08
  assign rail3_normal_code = code_field(rail3_voltage_code_r); // RULE_05
  assign rail3_sleep_code = code_field(rail3_sleep_control_r);
  assign rail3_target_nxt = rail3_sleep_active ? rail3_sleep_code : rail3_normal_code; // RULE_08

  // Byte addressed by the current request
  always @* begin
    rdata_nxt = read_select(REG_ADDR, rail2_control_r, rail3_decay_control_r,
      rail3_voltage_code_r, rail3_sleep_control_r); // RULE_09
  end

  // Read data only moves on a read strobe; between reads it holds the last answer
  always @* begin
    rdata_hold_nxt = REG_RDATA;
    if (REG_RD) begin
      rdata_hold_nxt = rdata_nxt;
    end
    rail2_code_nxt = code_field(rail2_control_r); // RULE_01
    rail2_decay_nxt = decay_field(rail2_control_r); // RULE_02
    rail3_decay_nxt = decay_field(rail3_decay_control_r); // RULE_03
  end

  // Read data register
  always @(posedge REF_CLK) begin
    if (!RESET_N) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rdata_hold_nxt;
    end
  end

  // Regulator controls follow the stored bytes one clock later
  always @(posedge REF_CLK) begin
    if (!RESET_N) begin
      RAIL2_VOLTAGE_CODE <= 7'h00;
      RAIL2_PASSIVE_DECAY_SELECT <= 1'h0;
      RAIL3_VOLTAGE_TARGET <= 7'h00;
      RAIL3_PASSIVE_DECAY_SELECT <= 1'h0;
    end else begin
      RAIL2_VOLTAGE_CODE <= rail2_code_nxt; // RULE_01
      RAIL2_PASSIVE_DECAY_SELECT <= rail2_decay_nxt; // RULE_02
      RAIL3_VOLTAGE_TARGET <= rail3_target_nxt; // RULE_08
      RAIL3_PASSIVE_DECAY_SELECT <= rail3_decay_nxt; // RULE_03
    end
  end
endmodule // buck_voltage_decay_regs

// file: hw/rail_byte_reg.v
`timescale 1ns/10ps
// One host-writable byte with a factory reset image and a write mask
module rail_byte_reg #(
  parameter [7:0] RESET_VALUE = 8'h00,
  parameter [7:0] WRITE_MASK = 8'hFF
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Write port
  input wire wr_en,
  input wire [7:0] wr_data,
  // Stored value
  output reg [7:0] q_r
);
  wire [7:0] q_nxt;

  // Masked bits keep their image, so they read as the factory value
  assign q_nxt = wr_en ? ((wr_data & WRITE_MASK) | (q_r & ~WRITE_MASK)) : q_r;

  always @(posedge clk) begin
    if (!reset_n) begin
      q_r <= RESET_VALUE & WRITE_MASK | RESET_VALUE & ~WRITE_MASK;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule // rail_byte_reg

// file: hw/rail_regs_consts.vh
`ifndef RAIL_REGS_CONSTS_VH
`define RAIL_REGS_CONSTS_VH
// Register offsets
`define RAIL2_CONTROL_OFS 8'h21
`define RAIL3_DECAY_CONTROL_OFS 8'h22
`define RAIL3_VOLTAGE_CODE_OFS 8'h23
`define RAIL3_SLEEP_CONTROL_OFS 8'h24
// Field positions
`define CODE_MSB 7
`define CODE_LSB 1
`define DECAY_BIT 0
`define SLEEP_EN_BIT 0
// Default factory images (overridden per variant by parameters)
`define RAIL2_CONTROL_DEF 8'h00
`define RAIL3_DECAY_CONTROL_DEF 8'h00
`define RAIL3_VOLTAGE_CODE_DEF 8'h00
`define RAIL3_SLEEP_CONTROL_DEF 8'h00
// Read data for unmapped offsets
`define UNMAPPED_DATA 8'h00
`endif

// file: verification/buck_voltage_decay_regs_bench.sv
`timescale 1ns/10ps
module buck_voltage_decay_regs_bench;
  reg clk = 1'b0, rst_n = 1'b0, slp_n = 1'b1;
  wire wr, rd, r2_dec, r3_dec;
  wire [7:0] adr, wd, rdat;
  wire [6:0] r2_code, r3_tgt;
  reg [7:0] d;
  integer error_cnt = 0, check_count = 0, cyc = 0;
  buck_voltage_decay_regs #(.RAIL2_CONTROL_INIT(8'h64), .RAIL3_DECAY_CONTROL_INIT(8'h40),
    .RAIL3_VOLTAGE_CODE_INIT(8'h41), .RAIL3_SLEEP_CONTROL_INIT(8'h21)) DUT (.REF_CLK(clk),
    .RESET_N(rst_n), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(adr), .REG_WDATA(wd), .REG_RDATA(rdat),
    .SLEEP_N(slp_n), .RAIL2_VOLTAGE_CODE(r2_code), .RAIL2_PASSIVE_DECAY_SELECT(r2_dec),
    .RAIL3_VOLTAGE_TARGET(r3_tgt), .RAIL3_PASSIVE_DECAY_SELECT(r3_dec));
  rail_host u_host (.REF_CLK(clk), .REG_RDATA(rdat), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(adr),
    .REG_WDATA(wd));
  initial forever #50 clk = ~clk;
  task final_report;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      error_cnt = error_cnt + 1;
      final_report;
    end
  end
  task chk(input string n, input [7:0] e, s);
    check_count = check_count + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task rchk(input [7:0] a, e);
    u_host.rd(a, d);
    chk("rdata", e, d);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h21, 8'h64);
    chk("r2", 8'h64, {r2_code, r2_dec});
    chk("r3dec", 8'h00, {7'h00, r3_dec});
    rchk(8'h22, 8'h40);
    rchk(8'h23, 8'h40);
    chk("r3tgt", 8'h20, {1'b0, r3_tgt});
    @(posedge clk) slp_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("r3tgt", 8'h10, {1'b0, r3_tgt});
    u_host.wr(8'h24, 8'hFE);
    rchk(8'h24, 8'hFE);
    chk("r3tgt", 8'h20, {1'b0, r3_tgt});
    @(posedge clk) slp_n <= 1'b1;
    u_host.wr(8'h21, 8'hA5);
    rchk(8'h21, 8'hA5);
    chk("r2", 8'hA5, {r2_code, r2_dec});
    u_host.wr(8'h21, 8'h5A);
    // The write lands at the task's last edge; the outputs follow one edge later
    @(posedge clk) #1 chk("r2", 8'h5A, {r2_code, r2_dec});
    u_host.wr(8'h22, 8'hFF);
    rchk(8'h22, 8'hFF);
    chk("r3dec", 8'h01, {7'h00, r3_dec});
    u_host.wr(8'h23, 8'hFF);
    rchk(8'h23, 8'hFE);
    chk("r3tgt", 8'h7F, {1'b0, r3_tgt});
    u_host.wr(8'h30, 8'hAA);
    rchk(8'h30, 8'h00);
    final_report;
  end
endmodule // buck_voltage_decay_regs_bench

// file: verification/rail_host.sv
`timescale 1ns/10ps
module rail_host (input REF_CLK, input [7:0] REG_RDATA, output reg REG_WR = 1'b0,
  output reg REG_RD = 1'b0, output reg [7:0] REG_ADDR = 8'h00, output reg [7:0] REG_WDATA = 8'h00);
  // Released address and data are inverted so stale values never look valid
  task wr(input [7:0] a, d);
    @(posedge REF_CLK) {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
    @(posedge REF_CLK) {REG_WR, REG_ADDR, REG_WDATA} <= {1'b0, ~a, ~d};
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge REF_CLK) {REG_RD, REG_ADDR} <= {1'b1, a};
    @(posedge REF_CLK) {REG_RD, REG_ADDR} <= {1'b0, ~a};
    @(posedge REF_CLK) #1 d = REG_RDATA;
  endtask
endmodule // rail_host

// file: verification/rail_props.sv
`timescale 1ns/10ps
module rail_props #(parameter [7:0] RAIL2_CONTROL_INIT = 8'h00) (
  input REF_CLK, RESET_N, REG_WR, REG_RD, SLEEP_N,
  input [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
  input [6:0] RAIL2_VOLTAGE_CODE, RAIL3_VOLTAGE_TARGET,
  input RAIL2_PASSIVE_DECAY_SELECT, RAIL3_PASSIVE_DECAY_SELECT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  sequence wr(a); REG_WR && REG_ADDR == a; endsequence
  // Idle gap keeps an in-between write from muddying the readback
  sequence wr_rd(a); wr(a) ##1 !REG_WR ##1 REG_RD && REG_ADDR == a; endsequence
  AST_R2_CODE: assert property (wr(8'h21) |=> ##1 RAIL2_VOLTAGE_CODE == $past(REG_WDATA[7:1], 2))
    else $error("rail2 code");
  AST_R2_DECAY: assert property (wr(8'h21) |=> ##1 RAIL2_PASSIVE_DECAY_SELECT == $past(REG_WDATA[0], 2))
    else $error("rail2 decay");
  AST_R3_DECAY: assert property (wr(8'h22) |=> ##1 RAIL3_PASSIVE_DECAY_SELECT == $past(REG_WDATA[0], 2))
    else $error("rail3 decay");
  AST_SPARE: assert property (wr_rd(8'h22) |=> REG_RDATA == $past(REG_WDATA, 3))
    else $error("spare readback");
  AST_R3_READ: assert property (wr_rd(8'h23) |=> REG_RDATA == {$past(REG_WDATA[7:1], 3), 1'b0})
    else $error("rail3 readback");
  AST_R3_TGT: assert property (wr(8'h23) ##0 SLEEP_N [*3] |-> RAIL3_VOLTAGE_TARGET == $past(REG_WDATA[7:1], 2))
    else $error("rail3 target");
  AST_RESET: assert property ($rose(RESET_N) |=> RAIL2_VOLTAGE_CODE == RAIL2_CONTROL_INIT[7:1])
    else $error("reset image");
  AST_RD_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved");
endmodule // rail_props
bind buck_voltage_decay_regs rail_props #(.RAIL2_CONTROL_INIT(RAIL2_CONTROL_INIT)) u_props (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .REG_WR(REG_WR), .REG_RD(REG_RD), .SLEEP_N(SLEEP_N),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .RAIL2_VOLTAGE_CODE(RAIL2_VOLTAGE_CODE), .RAIL3_VOLTAGE_TARGET(RAIL3_VOLTAGE_TARGET),
  .RAIL2_PASSIVE_DECAY_SELECT(RAIL2_PASSIVE_DECAY_SELECT),
  .RAIL3_PASSIVE_DECAY_SELECT(RAIL3_PASSIVE_DECAY_SELECT));
